// ---- rtl/plfx_consts.svh ----
// Constants for the pointer load, offset load and frame teardown executor.
// Assumes inclusion by the pacer and the executor files only.
`ifndef PLFX_CONSTS_SVH
`define PLFX_CONSTS_SVH

// Opcodes handled by this block.
`define PLFX_OP_LDSEG   8'hc5
`define PLFX_OP_LESEG   8'hc4
`define PLFX_OP_LEOFF   8'h8d
`define PLFX_OP_FRAME   8'hc9

// Instruction lengths in clocks, wide and narrow bus variants.
`define PLFX_CLK_PTR_W  6'd18
`define PLFX_CLK_PTR_N  6'd26
`define PLFX_CLK_LEA    6'd6
`define PLFX_CLK_FRAME  6'd8

// Address step to the segment half and the stack pop increment.
`define PLFX_WORD_STEP  16'h0002

`endif

// ---- rtl/plfx_pkg.sv ----
// Types shared by the executor and its cycle pacer.
// Assumes the constants header sits beside it in rtl/.
package plfx_pkg;

	// Kind of instruction in flight.
	typedef enum logic [2:0] {
		PLFX_NONE,
		PLFX_LDSEG,
		PLFX_LESEG,
		PLFX_LEOFF,
		PLFX_FRAME
	} plfx_kind_t;

	// Decoded request from the instruction decoder.
	typedef struct packed {
		logic [7:0]  opcode;
		logic [2:0]  regSel;
		logic [15:0] effOffset;
		logic [15:0] segBase;
	} plfx_req_t;

	// Register file write port: general register, segment registers, pointers.
	typedef struct packed {
		logic        gprWe;
		logic [2:0]  gprSel;
		logic [15:0] gprData;
		logic        dataSegWe;
		logic        extraSegWe;
		logic [15:0] segData;
		logic        stackPtrWe;
		logic [15:0] stackPtrData;
		logic        frameBaseWe;
		logic [15:0] frameBaseData;
	} plfx_wb_t;

	// Memory read request: segment and offset of one word.
	typedef struct packed {
		logic        rdReq;
		logic [15:0] seg;
		logic [15:0] off;
	} plfx_mem_t;

endpackage : plfx_pkg

// ---- rtl/plfx_pacer.sv ----
// Cycle pacer: counts an instruction's clocks and flags the one before its last.
// Assumes the start pulse comes only while the pacer is idle.
`timescale 1ns/10ps
`include "plfx_consts.svh"

module plfx_pacer #(
	parameter int CW = 6
) (
	// Clock and reset.
	input  wire logic          clock,
	input  wire logic          rst_n,
	// Control.
	input  wire logic          start,
	input  wire logic [CW-1:0] length,
	output logic               busy,
	output logic [CW-1:0]      count,
	output logic               last
);
	import plfx_pkg::*;

	// Counter must hold the longest instruction.
	if (CW < 5) begin : g_cw_check
		$error("plfx_pacer: counter too narrow");
	end

	logic [CW-1:0] lenQ;  // Length of current instruction.

	// Count advances every clock while busy and clears on the last; it restarts on start.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			lenQ  <= '0;
			busy  <= 1'b0;
		end else if (start) begin
			count <= CW'(1);
			lenQ  <= length;
			busy  <= 1'b1;
		end else if (last) begin
			busy  <= 1'b0;
			count <= '0;
		end else if (busy) begin
			count <= count + CW'(1);
		end
	end

	// The clock before the instruction's end: the owner registers its done
	// from this, so done stands on the clock that closes the instruction.
	assign last = busy && (count == lenQ - CW'(1));

endmodule : plfx_pacer

// ---- rtl/plfx_exec.sv ----
// Executor for far pointer loads, effective offset load and frame teardown.
// Assumes the register file supplies the frame base, stack segment and flags,
// and memory returns read data on the cycle after a read request.
`timescale 1ns/10ps
`include "plfx_consts.svh"

module plfx_exec #(
	parameter bit NARROW_BUS = 1'b0
) (
	// Clock and reset.
	input  wire logic               clock,
	input  wire logic               rst_n,
	// Decoder request.
	input  wire logic               reqValid,
	input  wire plfx_pkg::plfx_req_t req,
	output logic                    reqReady,
	// Register file view.
	input  wire logic [15:0]        frameBasePointer,
	input  wire logic [15:0]        stackSegment,
	input  wire logic [15:0]        flagsIn,
	// Memory read port.
	output plfx_pkg::plfx_mem_t     mem,
	input  wire logic [15:0]        memRdData,
	// Register write back.
	output plfx_pkg::plfx_wb_t      wb,
	output logic [15:0]             flagsOut,
	output logic                    done
);
	import plfx_pkg::*;

	//------------------------------------------------------------
	// Decode and pacing
	//------------------------------------------------------------

	typedef enum { ST_IDLE, ST_RUN } plfx_state_t;
	plfx_state_t stateQ;             // Executor state.
	plfx_kind_t  kindQ;              // Instruction in flight.
	plfx_req_t   reqQ;               // Captured request.
	logic [15:0] offHalfQ;           // Offset half of the pointer.
	logic [15:0] stackQ;             // Stack pointer during teardown.
	logic        startP;             // Starts the pacer.
	logic        busy;
	logic        last;
	logic [5:0]  count;
	logic [5:0]  length;

	// Opcode to kind.
	function automatic plfx_kind_t decode(input logic [7:0] op);
		if (op == `PLFX_OP_LDSEG)      return PLFX_LDSEG;
		else if (op == `PLFX_OP_LESEG) return PLFX_LESEG;
		else if (op == `PLFX_OP_LEOFF) return PLFX_LEOFF;
		else if (op == `PLFX_OP_FRAME) return PLFX_FRAME;
		else                           return PLFX_NONE;
	endfunction : decode

	// Clock count for each kind.
	function automatic logic [5:0] clocks(input plfx_kind_t k);
		case (k)
			PLFX_LDSEG, PLFX_LESEG: return NARROW_BUS ? `PLFX_CLK_PTR_N : `PLFX_CLK_PTR_W;
			PLFX_LEOFF: return `PLFX_CLK_LEA;
			PLFX_FRAME: return `PLFX_CLK_FRAME;
			default:    return 6'd1;
		endcase
	endfunction : clocks

	assign startP = (stateQ == ST_IDLE) && reqValid && (decode(req.opcode) != PLFX_NONE);
	assign length = clocks(decode(req.opcode));

	plfx_pacer #(.CW(6)) uPacer (
		.clock  (clock),
		.rst_n  (rst_n),
		.start  (startP),
		.length (length),
		.busy   (busy),
		.count  (count),
		.last   (last)
	);

	// State: accept a request when idle, return to idle on the last clock.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stateQ <= ST_IDLE;
			kindQ  <= PLFX_NONE;
			reqQ   <= '0;
		end else begin
			case (stateQ)
				ST_IDLE: begin
					if (startP) begin
						stateQ <= ST_RUN;
						kindQ  <= decode(req.opcode);
						reqQ   <= req;
					end
				end
				ST_RUN: begin
					if (last) begin
						stateQ <= ST_IDLE;
						kindQ  <= PLFX_NONE;
					end
				end
				default: stateQ <= ST_IDLE;
			endcase
		end
	end

	// Ready only while idle; unknown opcodes are simply not taken.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reqReady <= 1'b1;
		end else begin
			reqReady <= (stateQ == ST_IDLE) ? !startP : last;
		end
	end

	//------------------------------------------------------------
	// Memory reads
	//------------------------------------------------------------

	// Pointer loads read on clocks 2 and 3, the teardown pop on clock 2 only; data returns one clock later.
	// Later clocks just pad the instruction to its documented length.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mem <= '0;
		end else begin
			mem <= '0;
			if (stateQ == ST_RUN && (kindQ == PLFX_LDSEG || kindQ == PLFX_LESEG)) begin
				if (count == 6'd1) begin
					mem.rdReq <= 1'b1;
					mem.seg   <= reqQ.segBase;
					mem.off   <= reqQ.effOffset;
				end else if (count == 6'd2) begin
					mem.rdReq <= 1'b1;
					mem.seg   <= reqQ.segBase;
					mem.off   <= reqQ.effOffset + `PLFX_WORD_STEP;
				end
			end else if (stateQ == ST_RUN && kindQ == PLFX_FRAME && count == 6'd1) begin
				mem.rdReq <= 1'b1;
				mem.seg   <= stackSegment;
				mem.off   <= stackQ;
			end
		end
	end

	// Captures the offset half and the teardown stack pointer.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			offHalfQ <= '0;
			stackQ   <= '0;
		end else begin
			if (startP) begin
				stackQ <= frameBasePointer;
			end
			if (mem.rdReq && count == 6'd3) begin
				offHalfQ <= memRdData;
			end
		end
	end

	//------------------------------------------------------------
	// Write back
	//------------------------------------------------------------

	// All register writes land together on the last clock.
	// The segment half is taken at count 4, the one clock its data stands;
	// the narrow variant's extra clocks simply lengthen the wait after that.
	logic [15:0] segHalfQ;  // Segment half of the pointer.
	logic [15:0] popQ;      // Word popped into the frame base.

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			segHalfQ <= '0;
			popQ     <= '0;
		end else if ((kindQ == PLFX_LDSEG || kindQ == PLFX_LESEG) && count == 6'd4) begin
			segHalfQ <= memRdData;
		end else if (kindQ == PLFX_FRAME && count == 6'd3) begin
			popQ <= memRdData;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb   <= '0;
			done <= 1'b0;
		end else begin
			wb   <= '0;
			done <= last;
			if (last) begin
				case (kindQ)
					PLFX_LDSEG: begin
						wb.gprWe     <= 1'b1;
						wb.gprSel    <= reqQ.regSel;
						wb.gprData   <= offHalfQ;
						wb.dataSegWe <= 1'b1;
						wb.segData   <= segHalfQ;
					end
					PLFX_LESEG: begin
						wb.gprWe      <= 1'b1;
						wb.gprSel     <= reqQ.regSel;
						wb.gprData    <= offHalfQ;
						wb.extraSegWe <= 1'b1;
						wb.segData    <= segHalfQ;
					end
					PLFX_LEOFF: begin
						wb.gprWe   <= 1'b1;
						wb.gprSel  <= reqQ.regSel;
						wb.gprData <= reqQ.effOffset;
					end
					PLFX_FRAME: begin
						wb.stackPtrWe    <= 1'b1;
						wb.stackPtrData  <= stackQ + `PLFX_WORD_STEP;
						wb.frameBaseWe   <= 1'b1;
						wb.frameBaseData <= popQ;
					end
					default: wb <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flagsOut <= '0;
		end else begin
			flagsOut <= flagsIn;
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------

	sequence sPtrStart;
		startP && (decode(req.opcode) == PLFX_LDSEG || decode(req.opcode) == PLFX_LESEG);
	endsequence

	a_ptr_len_wide: assert property (@(posedge clock) disable iff (!rst_n)
		(sPtrStart and (!NARROW_BUS)) |-> ##18 done)
		else $error("pointer load length wrong");
	a_ptr_len_narrow: assert property (@(posedge clock) disable iff (!rst_n)
		(sPtrStart and (NARROW_BUS)) |-> ##26 done)
		else $error("narrow pointer load length wrong");
	a_lea_len: assert property (@(posedge clock) disable iff (!rst_n)
		startP && decode(req.opcode) == PLFX_LEOFF |-> ##6 done)
		else $error("offset load length wrong");
	a_frame_len: assert property (@(posedge clock) disable iff (!rst_n)
		startP && decode(req.opcode) == PLFX_FRAME |-> ##8 done)
		else $error("teardown length wrong");
	a_lea_no_read: assert property (@(posedge clock) disable iff (!rst_n)
		kindQ == PLFX_LEOFF |-> !mem.rdReq)
		else $error("offset load read memory");
	a_seg_word_step: assert property (@(posedge clock) disable iff (!rst_n)
		mem.rdReq && $past(mem.rdReq) && kindQ != PLFX_FRAME
		|-> mem.off == $past(mem.off) + `PLFX_WORD_STEP)
		else $error("segment word not two above");
	a_ds_write: assert property (@(posedge clock) disable iff (!rst_n)
		wb.dataSegWe |-> wb.gprWe && !wb.extraSegWe && wb.segData == segHalfQ)
		else $error("data segment write wrong");
	a_es_write: assert property (@(posedge clock) disable iff (!rst_n)
		wb.extraSegWe |-> wb.gprWe && !wb.dataSegWe)
		else $error("extra segment write wrong");
	a_frame_sp: assert property (@(posedge clock) disable iff (!rst_n)
		startP && decode(req.opcode) == PLFX_FRAME
		|-> ##8 wb.stackPtrData == $past(frameBasePointer, 8) + `PLFX_WORD_STEP)
		else $error("stack pointer not from frame base");
	a_pop_addr: assert property (@(posedge clock) disable iff (!rst_n)
		mem.rdReq && kindQ == PLFX_FRAME |-> mem.seg == stackSegment && mem.off == stackQ)
		else $error("pop address wrong");
	a_flags_kept: assert property (@(posedge clock) disable iff (!rst_n)
		busy |-> ##1 flagsOut == $past(flagsIn))
		else $error("flags changed");

endmodule : plfx_exec

// ---- verif/plfx_mem_model.sv ----
// Memory model on the far side of the executor's read port.
// Assumes one read request at a time, answered one clock after rdReq.
`timescale 1ns/10ps

module plfx_mem_model (
	// Clock and reset.
	input  wire logic                clock,
	input  wire logic                rst_n,
	// Read port from the executor.
	input  wire plfx_pkg::plfx_mem_t mem,
	output logic [15:0]              memRdData
);
	import plfx_pkg::*;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Each word is a mix of its segment and offset, so a wrong address shows.
	// Outside a read the bus inverts each clock, so data one clock stale cannot pass for a match.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			memRdData <= 16'h0000;
		end else if (mem.rdReq) begin
			memRdData <= mem.seg ^ mem.off ^ 16'ha5c3;
		end else begin
			memRdData <= ~memRdData;
		end
	end

endmodule : plfx_mem_model

// ---- verif/pointer_load_frame_exec_tb_top.sv ----
// Self-checking bench for the executor with a memory model beside it.
// Runs the wide and the narrow bus variant side by side on a 25 MHz core clock.
`timescale 1ns/10ps

module pointer_load_frame_exec_tb_top;
	import plfx_pkg::*;

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic        clock;       // Core clock.
	logic        rst_n;       // Reset, active low.
	logic        reqValid;    // Request strobe.
	plfx_req_t   req;         // Decoded request.
	logic        reqReady;    // Executor idle.
	logic [15:0] frameBase;   // Frame base pointer value.
	logic [15:0] stackSeg;    // Stack segment value.
	logic [15:0] flagsIn;     // Flags into the executor.
	plfx_mem_t   mem;         // Read request.
	logic [15:0] memRdData;   // Read data.
	plfx_wb_t    wb;          // Write back.
	logic [15:0] flagsOut;    // Flags out of the executor.
	logic        done;        // Completion pulse.
	int          mismatches;  // Failed comparisons.
	int          total_checks; // All comparisons.
	int          nClk;        // Clocks from take to done.
	int          nRd;         // Read requests seen.
	logic [15:0] rdOff [2];   // Offsets of the reads.
	logic [15:0] rdSeg;       // Segment of the last read.
	plfx_wb_t    wbSeen;      // Write back caught with the wide done.
	int          nClkN;       // Clocks from take to done, narrow variant.
	logic [15:0] segN;        // Segment half written by the narrow variant.
	plfx_mem_t   memN;        // Read request, narrow variant.
	logic [15:0] memRdDataN;  // Read data, narrow variant.
	plfx_wb_t    wbN;         // Write back, narrow variant.
	logic        doneN;       // Completion pulse, narrow variant.

	plfx_exec dut (.clock(clock), .rst_n(rst_n), .reqValid(reqValid), .req(req),
		.reqReady(reqReady), .frameBasePointer(frameBase), .stackSegment(stackSeg),
		.flagsIn(flagsIn), .mem(mem), .memRdData(memRdData), .wb(wb),
		.flagsOut(flagsOut), .done(done));
	plfx_mem_model memory (.clock(clock), .rst_n(rst_n), .mem(mem), .memRdData(memRdData));
	// Narrow bus variant, fed the same requests, to reach its longer timings.
	plfx_exec #(.NARROW_BUS(1'b1)) dutNarrow (.clock(clock), .rst_n(rst_n),
		.reqValid(reqValid), .req(req), .reqReady(), .frameBasePointer(frameBase),
		.stackSegment(stackSeg), .flagsIn(flagsIn), .mem(memN), .memRdData(memRdDataN),
		.wb(wbN), .flagsOut(), .done(doneN));
	plfx_mem_model memoryN (.clock(clock), .rst_n(rst_n), .mem(memN),
		.memRdData(memRdDataN));

	// Free running clock, 40 ns period.
	always #20 clock = ~clock;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Compares one value and counts the outcome.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	// Word the memory model holds at a segment and offset.
	function automatic logic [15:0] word_at(input logic [15:0] s, input logic [15:0] o);
		return s ^ o ^ 16'ha5c3;
	endfunction : word_at

	// Issues one request and counts clocks until done, logging reads meanwhile.
	task automatic run(input logic [7:0] op, input logic [2:0] r, input logic [15:0] ea,
			input logic [15:0] sb);
		@(posedge clock);
		reqValid <= 1'b1;
		req      <= '{opcode: op, regSel: r, effOffset: ea, segBase: sb};
		@(posedge clock);
		reqValid <= 1'b0;
		nClk  = 40;
		nClkN = 40;
		nRd   = 0;
		// A pulse seen after edge k-1 is sampled at edge k, so k is its clock count.
		for (int k = 1; k <= 40 && (nClk == 40 || nClkN == 40); k++) begin
			@(negedge clock);
			if (done === 1'b1 && nClk == 40) begin
				nClk   = k;
				wbSeen = wb;
			end
			if (doneN === 1'b1 && nClkN == 40) begin
				nClkN = k;
				segN  = wbN.segData;
			end
			if (mem.rdReq === 1'b1) begin
				if (nRd < 2) rdOff[nRd] = mem.off;
				rdSeg = mem.seg;
				nRd++;
			end
			@(posedge clock);
		end
		check(flagsOut, flagsIn, "flags");
	endtask : run

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Far pointer load into a data or extra segment; offset at the low word.
	task automatic ptr_load(input logic [7:0] op, input logic toExtra);
		run(op, 3'h6, 16'hfffe, 16'h2345);
		check(nClk, 18, "pointer load clocks");
		check(nClkN, 26, "narrow pointer load clocks");
		check(segN, word_at(16'h2345, 16'h0000), "narrow segment half");
		check(nRd, 2, "pointer load reads");
		check(rdOff[0], 16'hfffe, "offset address");
		check(rdOff[1], 16'h0000, "segment address");
		check(rdSeg, 16'h2345, "operand segment");
		check({wbSeen.gprWe, wbSeen.gprSel}, {1'b1, 3'h6}, "register write");
		check(wbSeen.gprData, word_at(16'h2345, 16'hfffe), "offset half");
		check(wbSeen.segData, word_at(16'h2345, 16'h0000), "segment half");
		check({wbSeen.dataSegWe, wbSeen.extraSegWe}, {~toExtra, toExtra}, "seg select");
	endtask : ptr_load

	// Offset load: no memory traffic, fixed length.
	task automatic offset_load;
		run(8'h8d, 3'h3, 16'h8421, 16'h1111);
		check(nClk, 6, "offset load clocks");
		check(nClkN, 6, "narrow offset load clocks");
		check(nRd, 0, "offset load reads");
		check({wbSeen.gprWe, wbSeen.gprSel, wbSeen.gprData}, {1'b1, 3'h3, 16'h8421},
			"offset");
	endtask : offset_load

	// Frame teardown: stack pointer from the frame base, then a pop.
	task automatic teardown;
		run(8'hc9, 3'h0, 16'h0000, 16'h0000);
		check(nClk, 8, "teardown clocks");
		check(nClkN, 8, "narrow teardown clocks");
		check(nRd, 1, "pop reads");
		check({rdSeg, rdOff[0]}, {stackSeg, frameBase}, "pop address");
		check({wbSeen.stackPtrWe, wbSeen.stackPtrData}, {1'b1, frameBase + 16'h0002},
			"stack");
		check({wbSeen.frameBaseWe, wbSeen.frameBaseData},
			{1'b1, word_at(stackSeg, frameBase)}, "frame base");
	endtask : teardown

	// A foreign opcode is never taken and raises nothing.
	task automatic foreign_op;
		run(8'h90, 3'h1, 16'h0100, 16'h0200);
		check(nClk, 40, "foreign opcode taken");
		check(nRd, 0, "foreign opcode read");
		check(reqReady, 1'b1, "still idle");
	endtask : foreign_op

	// ------------------------------------------------------------
	// Verdict
	// ------------------------------------------------------------
	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	// Watchdog, far beyond the roughly 130 clocks the scenarios need.
	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end

	// Main sequence.
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		reqValid = 1'b0;
		req = '0;
		frameBase = 16'h1230;
		stackSeg = 16'h0770;
		flagsIn = 16'h0ad5;
		mismatches = 0;
		total_checks = 0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		ptr_load(8'hc5, 1'b0);
		ptr_load(8'hc4, 1'b1);
		offset_load();
		teardown();
		foreign_op();
		wrap_up();
	end

endmodule : pointer_load_frame_exec_tb_top
